// file: hw/fte_host.v
// host controller that runs file transfers through device features
//
// Notes on behaviour
// - poll the trigger every 100 ms; never proceed until it reads zero
// - to store: choose file, direction write, operation open, fire trigger
// - read stored length first; if smaller than host file, go close
// - per write chunk set position to offset, count to min(rest, 988)
// - load window bytes, select write, fire; device stores at position
// - advance offset by bytes moved; loop while below size and outcome zero
// - to fetch, open with direction read; stored length is file size
// - per read chunk set count to min(rest, 988), select read, fire
// - device fills window from position; host reads it after trigger clears
// - finish by selecting close, firing trigger, and checking the outcome
//
// The implementer's own choices: the register addresses and the APB register port.
`include "fte_map.vh"
`timescale 1ns/1ns
`default_nettype none
module fte_host #(
    parameter POLL_CYCLES = `FTE_POLL_MS * `FTE_CLK_KHZ
) (
    input  wire        pclk,      // system clock, 125 MHz
    input  wire        presetn,   // async reset, active low
    input  wire [7:0]  paddr,     // software apb address
    input  wire        psel,      // software apb select
    input  wire        penable,   // software apb enable
    input  wire        pwrite,    // software apb direction
    input  wire [31:0] pwdata,    // software apb write data
    output reg  [31:0] prdata,    // software apb read data
    output reg         pready,    // software apb ready
    output reg         pslverr,   // unmapped address
    output reg         irq,       // level interrupt
    output reg  [15:0] m_paddr,   // feature bus address
    output reg         m_psel,    // feature bus select
    output reg         m_penable, // feature bus enable
    output reg         m_pwrite,  // feature bus direction
    output reg  [31:0] m_pwdata,  // feature bus write data
    input  wire [31:0] m_prdata,  // feature bus read data
    input  wire        m_pready   // feature bus ready
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam [17:0] S_IDLE = 18'h00001, S_SETF = 18'h00002,
                      S_SETD = 18'h00004, S_OPS  = 18'h00008,
                      S_TRIG = 18'h00010, S_WAIT = 18'h00020,
                      S_POLL = 18'h00040, S_STAT = 18'h00080,
                      S_LEN  = 18'h00100, S_CHK  = 18'h00200,
                      S_POS  = 18'h00400, S_CNT  = 18'h00800,
                      S_WREQ = 18'h01000, S_WWIN = 18'h02000,
                      S_MOV  = 18'h04000, S_RWIN = 18'h08000,
                      S_RREQ = 18'h10000, S_ADV  = 18'h20000;
    localparam [31:0] POLL_LAST = POLL_CYCLES - 1;

    reg  [17:0] state;
    reg  [1:0]  cur_op;
    reg  [31:0] timer;
    reg  [31:0] offset;
    reg  [31:0] slen;
    reg  [31:0] outcome;
    reg  [31:0] moved;
    reg  [9:0]  chunk;
    reg  [7:0]  word;
    reg  [31:0] rbuf;
    reg  [31:0] wbuf;
    reg         store;
    reg  [7:0]  file_sel;
    reg  [31:0] hsize;
    reg  [2:0]  istat;
    reg  [2:0]  imask;
    reg         ev_done;
    reg         ev_dreq;
    reg         ev_err;
    reg         acc;
    reg  [15:0] acc_addr;
    reg         acc_wr;
    reg  [31:0] acc_wdata;
    reg  [31:0] rd_mux;
    reg  [2:0]  next_istat;
    reg  [2:0]  next_imask;

    // ****************************************************************
    // software register decode
    // ****************************************************************
    function fte_mapped;
        input [7:0] a;
        begin
            fte_mapped = (a <= `FTE_R_IMASK) && (a[1:0] == 2'h0);
        end
    endfunction

    wire        sw_acc   = psel & penable & pready;
    wire        sw_wr    = sw_acc & pwrite & fte_mapped(paddr);
    wire        sw_rd    = sw_acc & ~pwrite & fte_mapped(paddr);
    wire        data_wr  = sw_wr & (paddr == `FTE_R_DATA);
    wire        data_rd  = sw_rd & (paddr == `FTE_R_DATA);
    wire        start    = sw_wr & (paddr == `FTE_R_CTRL) &
                           pwdata[`FTE_CTRL_START] & (state == S_IDLE);
    wire        acc_done = m_psel & m_penable & m_pready;
    wire [31:0] total    = store ? hsize : slen;
    wire [31:0] rest     = total - offset;
    wire [10:0] csum     = {1'b0, chunk} + 11'h003;
    wire [7:0]  nwords   = csum[9:2];
    wire [7:0]  word_nx  = word + 8'h01;

    // ****************************************************************
    // feature access request per state
    // ****************************************************************
    always @* begin
        acc       = 1'b1;
        acc_wr    = 1'b1;
        acc_addr  = `FTE_F_FILE;
        acc_wdata = 32'h00000000;
        case (state)
            S_SETF: acc_wdata = {24'h000000, file_sel};
            S_SETD: begin
                acc_addr  = `FTE_F_DIR;
                acc_wdata = store ? `FTE_DIR_WRITE : `FTE_DIR_READ;
            end
            S_OPS: begin
                acc_addr  = `FTE_F_OPSEL;
                acc_wdata = {30'h00000000, cur_op};
            end
            S_TRIG: begin
                acc_addr  = `FTE_F_TRIG;
                acc_wdata = `FTE_TRIG_GO;
            end
            S_POLL: begin
                acc_addr = `FTE_F_TRIG;
                acc_wr   = 1'b0;
            end
            S_STAT: begin
                acc_addr = `FTE_F_OUTC;
                acc_wr   = 1'b0;
            end
            S_LEN: begin
                acc_addr = `FTE_F_SLEN;
                acc_wr   = 1'b0;
            end
            S_POS: begin
                acc_addr  = `FTE_F_POS;
                acc_wdata = offset;
            end
            S_CNT: begin
                acc_addr  = `FTE_F_CNT;
                acc_wdata = {22'h000000, chunk};
            end
            S_WWIN: begin
                acc_addr  = `FTE_F_WIN + {6'h00, word, 2'h0};
                acc_wdata = wbuf;
            end
            S_MOV: begin
                acc_addr = `FTE_F_MOVED;
                acc_wr   = 1'b0;
            end
            S_RWIN: begin
                acc_addr = `FTE_F_WIN + {6'h00, word, 2'h0};
                acc_wr   = 1'b0;
            end
            default: acc = 1'b0;
        endcase
    end

    // ****************************************************************
    // feature bus master and sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_psel    <= 1'b0;
            m_penable <= 1'b0;
            m_pwrite  <= 1'b0;
            m_paddr   <= 16'h0000;
            m_pwdata  <= 32'h00000000;
            state     <= S_IDLE;
            cur_op    <= `FTE_OP_OPEN;
            timer     <= 32'h00000000;
            offset    <= 32'h00000000;
            slen      <= 32'h00000000;
            outcome   <= 32'h00000000;
            moved     <= 32'h00000000;
            chunk     <= 10'h000;
            word      <= 8'h00;
            rbuf      <= 32'h00000000;
            ev_done   <= 1'b0;
            ev_dreq   <= 1'b0;
            ev_err    <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            ev_dreq <= 1'b0;
            ev_err  <= 1'b0;
            if (acc && !m_psel) begin
                m_psel   <= 1'b1;
                m_paddr  <= acc_addr;
                m_pwrite <= acc_wr;
                m_pwdata <= acc_wdata;
            end else if (m_psel && !m_penable) begin
                m_penable <= 1'b1;
            end else if (acc_done) begin
                m_psel    <= 1'b0;
                m_penable <= 1'b0;
            end
            case (state)
                S_IDLE: if (start) begin
                    offset <= 32'h00000000;
                    cur_op <= `FTE_OP_OPEN;
                    state  <= S_SETF;
                end
                S_SETF: if (acc_done) state <= S_SETD;
                S_SETD: if (acc_done) state <= S_OPS;
                S_OPS:  if (acc_done) state <= S_TRIG;
                S_TRIG: if (acc_done) begin
                    timer <= 32'h00000000;
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    timer <= timer + 32'h00000001;
                    if (timer == POLL_LAST)
                        state <= S_POLL;
                end
                S_POLL: if (acc_done) begin
                    timer <= 32'h00000000;
                    state <= (m_prdata != 32'h00000000) ? S_WAIT
                                                        : S_STAT;
                end
                S_STAT: if (acc_done) begin
                    outcome <= m_prdata;
                    ev_err  <= (m_prdata != `FTE_OUT_OK);
                    case (cur_op)
                        `FTE_OP_OPEN:  state <= S_LEN;
                        `FTE_OP_CLOSE: begin
                            ev_done <= 1'b1;
                            state   <= S_IDLE;
                        end
                        default: state <= S_MOV;
                    endcase
                end
                S_LEN: if (acc_done) begin
                    slen  <= m_prdata;
                    state <= S_CHK;
                end
                S_CHK: begin
                    chunk <= (rest < {22'h000000, `FTE_WIN_BYTES}) ?
                             rest[9:0] : `FTE_WIN_BYTES;
                    if (outcome == `FTE_OUT_OK && offset < total &&
                        !(store && slen < hsize)) begin
                        cur_op <= store ? `FTE_OP_WRITE : `FTE_OP_READ;
                        state  <= S_POS;
                    end else begin
                        cur_op <= `FTE_OP_CLOSE;
                        state  <= S_OPS;
                    end
                end
                S_POS: if (acc_done) state <= S_CNT;
                S_CNT: if (acc_done) begin
                    word    <= 8'h00;
                    ev_dreq <= store;
                    state   <= store ? S_WREQ : S_OPS;
                end
                S_WREQ: if (data_wr) state <= S_WWIN;
                S_WWIN: if (acc_done) begin
                    word <= word_nx;
                    if (word_nx == nwords) begin
                        state <= S_OPS;
                    end else begin
                        ev_dreq <= 1'b1;
                        state   <= S_WREQ;
                    end
                end
                S_MOV: if (acc_done) begin
                    moved <= m_prdata;
                    word  <= 8'h00;
                    state <= store ? S_ADV : S_RWIN;
                end
                S_RWIN: if (acc_done) begin
                    rbuf    <= m_prdata;
                    ev_dreq <= 1'b1;
                    state   <= S_RREQ;
                end
                S_RREQ: if (data_rd) begin
                    word  <= word_nx;
                    state <= (word_nx == nwords) ? S_ADV : S_RWIN;
                end
                S_ADV: begin
                    offset <= offset + moved;
                    state  <= S_CHK;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // software registers and interrupt
    // ****************************************************************
    always @* begin
        next_istat = istat | {ev_err, ev_dreq, ev_done};
        next_imask = imask;
        if (sw_wr && paddr == `FTE_R_ISTAT)
            next_istat = (istat & ~pwdata[2:0]) | {ev_err, ev_dreq, ev_done};
        if (sw_wr && paddr == `FTE_R_IMASK)
            next_imask = pwdata[2:0];
        case (paddr)
            `FTE_R_CTRL:  rd_mux = {30'h00000000, store, 1'b0};
            `FTE_R_FILE:  rd_mux = {24'h000000, file_sel};
            `FTE_R_HSIZE: rd_mux = hsize;
            `FTE_R_DATA:  rd_mux = rbuf;
            `FTE_R_STAT:  rd_mux = {30'h00000000,
                                    state == S_WREQ || state == S_RREQ,
                                    state != S_IDLE};
            `FTE_R_OUTC:  rd_mux = outcome;
            `FTE_R_OFFS:  rd_mux = offset;
            `FTE_R_SLEN:  rd_mux = slen;
            `FTE_R_ISTAT: rd_mux = {29'h00000000, istat};
            `FTE_R_IMASK: rd_mux = {29'h00000000, imask};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready   <= 1'b0;
            prdata   <= 32'h00000000;
            pslverr  <= 1'b0;
            store    <= 1'b0;
            file_sel <= 8'h00;
            hsize    <= 32'h00000000;
            wbuf     <= 32'h00000000;
            istat    <= 3'h0;
            imask    <= 3'h0;
            irq      <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~fte_mapped(paddr);
            if (psel && penable && !pready)
                prdata <= fte_mapped(paddr) ? rd_mux : 32'h00000000;
            if (sw_wr && paddr == `FTE_R_CTRL && state == S_IDLE)
                store <= pwdata[`FTE_CTRL_STORE];
            if (sw_wr && paddr == `FTE_R_FILE && state == S_IDLE)
                file_sel <= pwdata[7:0];
            if (sw_wr && paddr == `FTE_R_HSIZE && state == S_IDLE)
                hsize <= pwdata;
            if (data_wr)
                wbuf <= pwdata;
            istat <= next_istat;
            imask <= next_imask;
            irq   <= |(next_istat & next_imask);
        end
    end
endmodule
`default_nettype wire

// file: hw/fte_map.vh
// constants for the file transfer host controller
`ifndef FTE_MAP_VH
`define FTE_MAP_VH
// ****************************************************************
// device feature addresses on the feature bus
// ****************************************************************
`define FTE_F_FILE   16'h0000
`define FTE_F_DIR    16'h0004
`define FTE_F_OPSEL  16'h0008
`define FTE_F_TRIG   16'h000C
`define FTE_F_OUTC   16'h0010
`define FTE_F_SLEN   16'h0014
`define FTE_F_POS    16'h0018
`define FTE_F_CNT    16'h001C
`define FTE_F_MOVED  16'h0020
`define FTE_F_WIN    16'h0400
// ****************************************************************
// feature values
// ****************************************************************
`define FTE_OP_OPEN  2'h0
`define FTE_OP_CLOSE 2'h1
`define FTE_OP_READ  2'h2
`define FTE_OP_WRITE 2'h3
`define FTE_DIR_READ  32'h00000000
`define FTE_DIR_WRITE 32'h00000001
`define FTE_TRIG_GO   32'h00000001
`define FTE_WIN_BYTES 10'h3DC
// outcome codes as seen on the device; anything nonzero is an error
`define FTE_OUT_OK    32'h00000000
// ****************************************************************
// software register offsets and fields
// ****************************************************************
`define FTE_R_CTRL   8'h00
`define FTE_R_FILE   8'h04
`define FTE_R_HSIZE  8'h08
`define FTE_R_DATA   8'h0C
`define FTE_R_STAT   8'h10
`define FTE_R_OUTC   8'h14
`define FTE_R_OFFS   8'h18
`define FTE_R_SLEN   8'h1C
`define FTE_R_ISTAT  8'h20
`define FTE_R_IMASK  8'h24
`define FTE_CTRL_START 0
`define FTE_CTRL_STORE 1
`define FTE_STAT_BUSY  0
`define FTE_STAT_DREQ  1
`define FTE_IRQ_DONE   0
`define FTE_IRQ_DREQ   1
`define FTE_IRQ_ERR    2
// ****************************************************************
// timing
// ****************************************************************
`define FTE_POLL_MS  100
`define FTE_CLK_KHZ  125000
`endif

// file: dv/fte_host_asserts.sv
// port checker for the file transfer host controller
`timescale 1ns/1ns
`default_nettype none
`include "fte_map.vh"
module fte_chk #(
    parameter POLL_CYCLES = 4
) (
    input wire logic        pclk,      // clock
    input wire logic        presetn,   // reset, active low
    input wire logic        psel,      // apb select
    input wire logic        penable,   // apb enable
    input wire logic        pready,    // apb ready
    input wire logic        pslverr,   // apb error
    input wire logic [15:0] m_paddr,   // feature address
    input wire logic        m_psel,    // feature select
    input wire logic        m_penable, // feature enable
    input wire logic        m_pwrite,  // feature direction
    input wire logic [31:0] m_pwdata,  // feature write data
    input wire logic        m_pready   // feature ready
);
    // ****************************************************************
    // idle cycles since the last feature access
    // ****************************************************************
    logic [31:0] gap;
    logic        fw;
    assign fw = m_psel & m_pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap <= 32'h0;
        else if (m_psel) gap <= 32'h0;
        else gap <= gap + 32'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");
    ready_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("apb ready not after one wait state");
    err_ready_a: assert property (pslverr |-> pready && psel)
        else $error("apb error outside an answer");
    req_hold_a: assert property (m_psel && !(m_penable && m_pready) |=>
        m_psel && $stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite))
        else $error("feature request changed before ready");
    setup_a: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable)
        else $error("feature setup phase wrong");
    access_end_a: assert property (m_psel && m_penable && m_pready |=>
        !m_psel) else $error("feature select held after ready");
    trig_one_a: assert property (fw && m_paddr == `FTE_F_TRIG |->
        m_pwdata == `FTE_TRIG_GO) else $error("trigger value not one");
    op_code_a: assert property (fw && m_paddr == `FTE_F_OPSEL |->
        m_pwdata < 32'h4) else $error("operation code out of range");
    dir_code_a: assert property (fw && m_paddr == `FTE_F_DIR |->
        m_pwdata[31:1] == 31'h0) else $error("direction value bad");
    count_cap_a: assert property (fw && m_paddr == `FTE_F_CNT |->
        m_pwdata != 32'h0 && m_pwdata <= 32'h3DC)
        else $error("chunk count out of range");
    poll_gap_a: assert property ($rose(m_psel) && !m_pwrite &&
        m_paddr == `FTE_F_TRIG |-> gap >= POLL_CYCLES - 1)
        else $error("trigger polled too soon");
endmodule
bind fte_host fte_chk #(.POLL_CYCLES(POLL_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .m_paddr(m_paddr),
    .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite),
    .m_pwdata(m_pwdata), .m_pready(m_pready));
`default_nettype wire

// file: dv/fte_dev.sv
// behavioural model of the file storage device on the feature bus
`timescale 1ns/1ns
`default_nettype none
`include "fte_map.vh"
module fte_dev #(
    parameter logic [7:0] BUSY = 8'h0C
) (
    input  wire logic        pclk,      // clock
    input  wire logic        presetn,   // reset, active low
    input  wire logic [15:0] m_paddr,   // address
    input  wire logic        m_psel,    // select
    input  wire logic        m_penable, // enable
    input  wire logic        m_pwrite,  // direction
    input  wire logic [31:0] m_pwdata,  // write data
    output var  logic [31:0] m_prdata,  // read data
    output var  logic        m_pready   // ready
);
    // ****************************************************************
    // feature state and file storage
    // ****************************************************************
    localparam logic [31:0] CAP = 32'h1000;
    logic [31:0] fsel, dir, op, outc, slen, pos, cnt, moved, flen;
    logic [7:0]  busy, tick;
    logic [1:0]  ws;
    logic        opened;
    logic [7:0]  mem [0:4095];
    logic [31:0] win [0:246];
    function automatic logic [31:0] rd(input logic [15:0] a);
        case (a)
            `FTE_F_TRIG:  rd = {31'h0, busy != 8'h0};
            `FTE_F_OUTC:  rd = outc;
            `FTE_F_SLEN:  rd = slen;
            `FTE_F_MOVED: rd = moved;
            default: rd = (a >= `FTE_F_WIN) ? win[(a - `FTE_F_WIN) >> 2] : 0;
        endcase
    endfunction
    task automatic run_op;
        int i;
        moved = 32'h0;
        outc = 32'h0;
        if (op[1:0] == `FTE_OP_OPEN) begin
            slen = 32'h0;
            if (fsel == 32'h0 || fsel > 32'h2) outc = 32'h5;
            else if (fsel == 32'h2 && dir[0]) outc = 32'h2;
            else begin
                opened = 1'b1;
                if (dir[0]) flen = 32'h0;
                slen = dir[0] ? CAP : flen;
            end
        end else if (!opened) outc = 32'h3;
        else if (op[1:0] == `FTE_OP_CLOSE) opened = 1'b0;
        else if (cnt > 32'h3DC) outc = 32'h1;
        else if (op[0]) begin
            if (pos + cnt > CAP) outc = 32'h4;
            else begin
                for (i = 0; i < cnt; i++)
                    mem[pos + i] = win[i / 4][8 * (i % 4) +: 8];
                moved = cnt;
                if (pos + cnt > flen) flen = pos + cnt;
            end
        end else begin
            moved = (pos + cnt > flen) ? flen - pos : cnt;
            for (i = 0; i < moved; i++)
                win[i / 4][8 * (i % 4) +: 8] = mem[pos + i];
        end
    endtask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_pready <= 1'b0;
            m_prdata <= 32'h0;
            busy <= 8'h0;
            tick <= 8'h0;
            ws <= 2'h0;
            opened = 1'b0;
            flen = 32'h0;
        end else begin
            tick <= tick + 8'h1;
            if (busy == 8'h1) run_op;
            if (busy != 8'h0) busy <= busy - 8'h1;
            m_pready <= 1'b0;
            m_prdata <= ~m_prdata;
            if (m_psel && m_penable && !m_pready) begin
                if (ws != 2'h0) ws <= ws - 2'h1;
                else begin
                    m_pready <= 1'b1;
                    m_prdata <= rd(m_paddr);
                    ws <= tick[2:1];
                end
            end
            if (m_psel && m_penable && m_pready && m_pwrite)
                case (m_paddr)
                    `FTE_F_FILE:  fsel <= m_pwdata;
                    `FTE_F_DIR:   dir <= m_pwdata;
                    `FTE_F_OPSEL: op <= m_pwdata;
                    `FTE_F_TRIG:  busy <= BUSY;
                    `FTE_F_POS:   pos <= m_pwdata;
                    `FTE_F_CNT:   cnt <= m_pwdata;
                    default: if (m_paddr >= `FTE_F_WIN)
                        win[(m_paddr - `FTE_F_WIN) >> 2] = m_pwdata;
                endcase
        end
    end
endmodule
`default_nettype wire

// file: dv/fte_host_tb_top.sv
// self-checking bench for the file transfer host controller
`timescale 1ns/1ns
`default_nettype none
`include "fte_map.vh"
module fte_host_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        irq, m_psel, m_penable, m_pwrite, m_pready, e;
    logic [7:0]  paddr;
    logic [15:0] m_paddr;
    logic [31:0] pwdata, prdata, m_pwdata, m_prdata, q, n, w, seed;
    logic [7:0]  data [0:2047];
    int          fails, num_checks, i, c;
    fte_host #(.POLL_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .m_paddr(m_paddr), .m_psel(m_psel),
        .m_penable(m_penable), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata),
        .m_prdata(m_prdata), .m_pready(m_pready));
    fte_dev dev (.pclk(pclk), .presetn(presetn), .m_paddr(m_paddr),
        .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite),
        .m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk("pready", 32'h1, 32'h0);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask
    task xfer(input logic [31:0] f, input logic s, input logic [31:0] sz);
        logic [31:0] st;
        int b, k;
        apb(1'b1, `FTE_R_FILE, f);
        apb(1'b1, `FTE_R_HSIZE, sz);
        apb(1'b1, `FTE_R_CTRL, {30'h0, s, 1'b1});
        w = 32'h0;
        k = 0;
        do begin
            apb(1'b0, `FTE_R_STAT, 32'h0);
            st = q;
            k++;
            if (st[`FTE_STAT_DREQ] === 1'b1 && s) begin
                apb(1'b1, `FTE_R_DATA,
                    {data[4*w+3], data[4*w+2], data[4*w+1], data[4*w]});
                w++;
            end else if (st[`FTE_STAT_DREQ] === 1'b1) begin
                apb(1'b0, `FTE_R_DATA, 32'h0);
                for (b = 0; b < 4; b++)
                    if (4 * w + b < sz)
                        chk("fetched byte", {24'h0, data[4*w+b]},
                            {24'h0, q[8*b +: 8]});
                w++;
            end
        end while (st[`FTE_STAT_BUSY] !== 1'b0 && k < 20000);
        chk("busy end", 32'h0, {31'h0, st[`FTE_STAT_BUSY]});
    endtask
    task complete_run;
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        #800000;
        fails++;
        complete_run;
    end
    initial begin
        seed = 32'h8CBC5D87;
        {fails, num_checks} = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        for (i = 0; i < 2048; i++) data[i] = $random(seed);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk("stat reset", `FTE_R_STAT, 32'h0);
        rchk("istat reset", `FTE_R_ISTAT, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, `FTE_R_IMASK, 32'h5);
        for (c = 0; c < 2; c++) begin
            n = (c == 0) ? 32'h3DC : 32'h3DD + ($random(seed) & 32'h3FF);
            xfer(32'h1, 1'b1, n);
            chk("store words", (n + 3) / 4, w);
            rchk("store outcome", `FTE_R_OUTC, 32'h0);
            rchk("store offset", `FTE_R_OFFS, n);
            for (i = 0; i < n; i++)
                chk("stored", {24'h0, data[i]}, {24'h0, dev.mem[i]});
            rchk("istat done", `FTE_R_ISTAT, 32'h3);
            chk("irq done", 32'h1, {31'h0, irq});
            apb(1'b1, `FTE_R_ISTAT, 32'h7);
            rchk("istat clear", `FTE_R_ISTAT, 32'h0);
            chk("irq clear", 32'h0, {31'h0, irq});
            xfer(32'h1, 1'b0, n);
            chk("fetch words", (n + 3) / 4, w);
            rchk("stored length", `FTE_R_SLEN, n);
            rchk("fetch offset", `FTE_R_OFFS, n);
            rchk("fetch outcome", `FTE_R_OUTC, 32'h0);
            apb(1'b1, `FTE_R_ISTAT, 32'h7);
        end
        xfer(32'h1, 1'b1, 32'h1388);
        chk("skip words", 32'h0, w);
        rchk("skip offset", `FTE_R_OFFS, 32'h0);
        xfer(32'h2, 1'b1, 32'h64);
        chk("protect words", 32'h0, w);
        rchk("protect outcome", `FTE_R_OUTC, 32'h3);
        rchk("istat error", `FTE_R_ISTAT, 32'h5);
        chk("irq error", 32'h1, {31'h0, irq});
        apb(1'b1, `FTE_R_IMASK, 32'h0);
        rchk("imask", `FTE_R_IMASK, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(32'h7, 1'b0, 32'h64);
        chk("absent words", 32'h0, w);
        rchk("absent outcome", `FTE_R_OUTC, 32'h3);
        complete_run;
    end
endmodule
`default_nettype wire
